// >>> rtl/pfs_pkg.sv
// ==================================================================
// Shared constants of the pin function selection block.
// ==================================================================
package pfs_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [15:0] PFS_IDX_P15 = 16'ha05d;
  localparam logic [15:0] PFS_IDX_P16 = 16'ha05e;
  localparam logic [15:0] PFS_IDX_P17 = 16'ha05f;
  localparam logic [15:0] PFS_IDX_P20 = 16'ha070;
  localparam logic [15:0] PFS_IDX_P21 = 16'ha071;
  localparam logic [15:0] PFS_IDX_P22 = 16'ha072;
  localparam logic [15:0] PFS_IDX_P23 = 16'ha073;
  localparam logic [15:0] PFS_IDX_P24 = 16'ha074;

  // Width of the APB byte address.
  localparam int PFS_ADDR_W = 18;

  // Register width, count and reset value.
  localparam int PFS_REG_W = 8;
  localparam int PFS_NPIN = 8;
  localparam logic [7:0] PFS_CFG_RST = 8'h00;

  // Position of each pin inside the pin vectors.
  localparam int PFS_PIN_P15 = 0;
  localparam int PFS_PIN_P16 = 1;
  localparam int PFS_PIN_P17 = 2;
  localparam int PFS_PIN_P20 = 3;
  localparam int PFS_PIN_P21 = 4;
  localparam int PFS_PIN_P22 = 5;
  localparam int PFS_PIN_P23 = 6;
  localparam int PFS_PIN_P24 = 7;

  // Field positions shared by every configuration register.
  localparam int PFS_BIT_GPIO = 0;
  localparam int PFS_BIT_IRQ0 = 1;
  localparam int PFS_BIT_IRQ1 = 2;
  localparam int PFS_BIT_FN3 = 3;
  localparam int PFS_BIT_FN4 = 4;
  localparam int PFS_BIT_FN5 = 5;
  localparam int PFS_BIT_FN6 = 6;
  localparam int PFS_BIT_ANALOG = 7;

  // Bits that may select a pin driver, searched from the top down.
  localparam logic [7:0] PFS_DRIVE_BITS = 8'hf9;

endpackage : pfs_pkg

// >>> rtl/pfs_pin_select.sv
`timescale 1ns/10ps
module pfs_pin_select (
  input wire logic pclk, // APB clock, 40 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [pfs_pkg::PFS_ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB write strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped addresses.
  input wire logic [7:0] pin_in, // Pad input levels.
  output logic [7:0] pin_out, // Pad output levels.
  output logic [7:0] pin_oe_n, // Pad output enables, low drives.
  input wire logic [7:0] gpio_out, // GPIO output data.
  input wire logic [7:0] gpio_oe, // GPIO output enables, high drives.
  output logic [7:0] gpio_in, // Pin levels seen by GPIO.
  output logic shared_pin_irq_group0, // Combined group zero condition.
  output logic shared_pin_irq_group1, // Combined group one condition.
  output logic [7:0] pad_analog_select, // Analog path connect per pin.
  input wire logic i2c_master_sda_out, // Master data, low pulls the line.
  input wire logic i2c_master_scl_out, // Master clock, low pulls the line.
  input wire logic i2c_slave1_sda_out, // Slave one data, low pulls the line.
  input wire logic i2c_slave1_scl_out, // Slave one clock, low pulls the line.
  input wire logic i2c_slave2_sda_out, // Slave two data, low pulls the line.
  output logic i2c_master_sda_in, // Master data line level.
  output logic i2c_master_scl_in, // Master clock line level.
  output logic i2c_slave1_sda_in, // Slave one data line level.
  output logic i2c_slave1_scl_in, // Slave one clock line level.
  output logic i2c_slave2_sda_in, // Slave two data line level.
  input wire logic motor_pwm_b_neg_out, // PWM channel B negative.
  input wire logic motor_pwm_b_pos_out, // PWM channel B positive.
  input wire logic motor_pwm_c_pos_out, // PWM channel C positive.
  output logic pwm_emergency_in, // PWM emergency stop input.
  input wire logic [3:0] capcomp_out, // Channels 0, 1, 4, 5 output data.
  input wire logic [3:0] capcomp_oe, // Channels 0, 1, 4, 5 output enables.
  output logic [3:0] capcomp_in, // Channels 0, 1, 4, 5 input levels.
  output logic timer0_count_in, // Timer 0 count input.
  output logic timer1_count_in, // Timer 1 count input.
  output logic timer2_input_in, // Timer 2 external input.
  input wire logic spi_mosi_out, // SPI MOSI output data.
  input wire logic spi_mosi_oe, // SPI MOSI output enable.
  input wire logic spi_miso_out, // SPI MISO output data.
  input wire logic spi_miso_oe, // SPI MISO output enable.
  input wire logic spi_sck_out, // SPI clock output data.
  input wire logic spi_sck_oe, // SPI clock output enable.
  output logic spi_mosi_in, // SPI MOSI level.
  output logic spi_miso_in, // SPI MISO level.
  output logic spi_sck_in, // SPI clock level.
  output logic spi_ssn_in, // SPI slave select, active low.
  input wire logic uart2_txd_out, // Second UART transmit data.
  output logic uart2_rxd_in // Second UART receive level.
);
  import pfs_pkg::*;

  // ==================================================================
  // State
  // ==================================================================
  typedef struct packed {
    logic [PFS_NPIN-1:0][PFS_REG_W-1:0] cfg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
    logic [7:0] gpio_in;
    logic irq0;
    logic irq1;
    logic [7:0] analog;
    logic m_sda;
    logic m_scl;
    logic s1_sda;
    logic s1_scl;
    logic s2_sda;
    logic pwm_emergency_stop;
    logic [3:0] cc_in;
    logic t0;
    logic t1;
    logic t2;
    logic mosi;
    logic miso;
    logic sck;
    logic ssn;
    logic rxd;
  } pfs_state_t;

  pfs_state_t st_r;
  pfs_state_t st_nxt;

  // ==================================================================
  // Functions
  // ==================================================================
  // Maps a byte address to {hit, register number}.
  function automatic logic [3:0] pfs_decode(input logic [PFS_ADDR_W-1:0] a);
    logic [3:0] r;
    r = 4'h0;
    if (a == PFS_ADDR_W'({PFS_IDX_P15, 2'b00})) begin
      r = {1'b1, 3'(PFS_PIN_P15)};
    end else if (a == PFS_ADDR_W'({PFS_IDX_P16, 2'b00})) begin
      r = {1'b1, 3'(PFS_PIN_P16)};
    end else if (a == PFS_ADDR_W'({PFS_IDX_P17, 2'b00})) begin
      r = {1'b1, 3'(PFS_PIN_P17)};
    end else if (a == PFS_ADDR_W'({PFS_IDX_P20, 2'b00})) begin
      r = {1'b1, 3'(PFS_PIN_P20)};
    end else if (a == PFS_ADDR_W'({PFS_IDX_P21, 2'b00})) begin
      r = {1'b1, 3'(PFS_PIN_P21)};
    end else if (a == PFS_ADDR_W'({PFS_IDX_P22, 2'b00})) begin
      r = {1'b1, 3'(PFS_PIN_P22)};
    end else if (a == PFS_ADDR_W'({PFS_IDX_P23, 2'b00})) begin
      r = {1'b1, 3'(PFS_PIN_P23)};
    end else if (a == PFS_ADDR_W'({PFS_IDX_P24, 2'b00})) begin
      r = {1'b1, 3'(PFS_PIN_P24)};
    end
    return r;
  endfunction : pfs_decode

  // Picks {drive, level} from the highest set bit that may drive the pin.
  function automatic logic [1:0] pfs_pick(input logic [7:0] c, input logic [7:0] dout,
                                          input logic [7:0] den);
    logic [1:0] r;
    logic found;
    r = 2'b00;
    found = 1'b0;
    for (int b = 7; b >= 0; b--) begin
      if (!found && c[b] && PFS_DRIVE_BITS[b]) begin
        found = 1'b1;
        r = {den[b], dout[b]};
      end
    end
    return r;
  endfunction : pfs_pick

  // ==================================================================
  // Next state
  // ==================================================================
  // Register access, pin drive selection and input routing.
  always_comb begin
    logic [7:0] dout [PFS_NPIN];
    logic [7:0] den [PFS_NPIN];
    logic [3:0] dec;
    logic [1:0] pk;
    logic [PFS_NPIN-1:0][PFS_REG_W-1:0] c;
    for (int p = 0; p < PFS_NPIN; p++) begin
      dout[p] = 8'h00;
      den[p] = 8'h00;
    end
    dec = pfs_decode(paddr);
    pk = 2'b00;
    st_nxt = st_r;
    c = st_r.cfg;

    // APB: answer is prepared in the setup cycle, ready in the access cycle.
    st_nxt.pready = psel && !penable;
    st_nxt.pslverr = psel && !penable && !dec[3];
    st_nxt.prdata = 32'h0;
    if (psel && !penable && dec[3] && !pwrite) begin
      st_nxt.prdata = {24'h0, c[dec[2:0]]};
    end
    if (psel && penable && st_r.pready && pwrite && dec[3] && pstrb[0]) begin
      st_nxt.cfg[dec[2:0]] = pwdata[PFS_REG_W-1:0];
    end

    // GPIO driver on bit 0 of every pin; analog bit 7 leaves the pad undriven.
    for (int p = 0; p < PFS_NPIN; p++) begin
      dout[p][PFS_BIT_GPIO] = gpio_out[p];
      den[p][PFS_BIT_GPIO] = gpio_oe[p];
    end

    // P1.5 functions; open-drain lines only ever pull low.
    den[PFS_PIN_P15][PFS_BIT_FN6] = !i2c_slave2_sda_out;
    dout[PFS_PIN_P15][PFS_BIT_FN5] = motor_pwm_b_neg_out;
    den[PFS_PIN_P15][PFS_BIT_FN5] = 1'b1;
    den[PFS_PIN_P15][PFS_BIT_FN4] = !i2c_master_sda_out;
    // P1.6 functions; timer input on bit 6 leaves the pad undriven.
    dout[PFS_PIN_P16][PFS_BIT_FN5] = motor_pwm_b_pos_out;
    den[PFS_PIN_P16][PFS_BIT_FN5] = 1'b1;
    dout[PFS_PIN_P16][PFS_BIT_FN4] = capcomp_out[0];
    den[PFS_PIN_P16][PFS_BIT_FN4] = capcomp_oe[0];
    // P1.7 functions.
    dout[PFS_PIN_P17][PFS_BIT_FN5] = motor_pwm_b_neg_out;
    den[PFS_PIN_P17][PFS_BIT_FN5] = 1'b1;
    dout[PFS_PIN_P17][PFS_BIT_FN4] = capcomp_out[1];
    den[PFS_PIN_P17][PFS_BIT_FN4] = capcomp_oe[1];
    // P2.0 functions.
    den[PFS_PIN_P20][PFS_BIT_FN6] = !i2c_master_scl_out;
    den[PFS_PIN_P20][PFS_BIT_FN5] = !i2c_slave1_scl_out;
    dout[PFS_PIN_P20][PFS_BIT_FN4] = capcomp_out[2];
    den[PFS_PIN_P20][PFS_BIT_FN4] = capcomp_oe[2];
    dout[PFS_PIN_P20][PFS_BIT_FN3] = spi_mosi_out;
    den[PFS_PIN_P20][PFS_BIT_FN3] = spi_mosi_oe;
    // P2.1 functions.
    den[PFS_PIN_P21][PFS_BIT_FN6] = !i2c_master_sda_out;
    den[PFS_PIN_P21][PFS_BIT_FN5] = !i2c_slave1_sda_out;
    dout[PFS_PIN_P21][PFS_BIT_FN4] = capcomp_out[3];
    den[PFS_PIN_P21][PFS_BIT_FN4] = capcomp_oe[3];
    dout[PFS_PIN_P21][PFS_BIT_FN3] = spi_miso_out;
    den[PFS_PIN_P21][PFS_BIT_FN3] = spi_miso_oe;
    // P2.2 functions; emergency input on bit 5 leaves the pad undriven.
    dout[PFS_PIN_P22][PFS_BIT_FN4] = uart2_txd_out;
    den[PFS_PIN_P22][PFS_BIT_FN4] = 1'b1;
    dout[PFS_PIN_P22][PFS_BIT_FN3] = spi_sck_out;
    den[PFS_PIN_P22][PFS_BIT_FN3] = spi_sck_oe;
    // P2.4 functions; P2.3 has no driver besides GPIO bit 0.
    dout[PFS_PIN_P24][PFS_BIT_FN5] = motor_pwm_c_pos_out;
    den[PFS_PIN_P24][PFS_BIT_FN5] = 1'b1;

    // Resolve each pad from its configuration.
    for (int p = 0; p < PFS_NPIN; p++) begin
      pk = pfs_pick(c[p], dout[p], den[p]);
      st_nxt.pin_out[p] = pk[0];
      st_nxt.pin_oe_n[p] = !pk[1];
      st_nxt.gpio_in[p] = c[p][PFS_BIT_GPIO] && pin_in[p];
      st_nxt.analog[p] = c[p][PFS_BIT_ANALOG];
    end

    // Shared interrupt groups combine every selected pin level.
    st_nxt.irq0 = 1'b0;
    st_nxt.irq1 = 1'b0;
    for (int p = 0; p < PFS_NPIN; p++) begin
      st_nxt.irq0 = st_nxt.irq0 || (c[p][PFS_BIT_IRQ0] && pin_in[p]);
      st_nxt.irq1 = st_nxt.irq1 || (c[p][PFS_BIT_IRQ1] && pin_in[p]);
    end

    // Peripheral inputs; unselected idle-high lines read as one.
    st_nxt.m_sda = (!c[PFS_PIN_P15][PFS_BIT_FN4] || pin_in[PFS_PIN_P15])
                && (!c[PFS_PIN_P21][PFS_BIT_FN6] || pin_in[PFS_PIN_P21]);
    st_nxt.m_scl = !c[PFS_PIN_P20][PFS_BIT_FN6] || pin_in[PFS_PIN_P20];
    st_nxt.s1_scl = !c[PFS_PIN_P20][PFS_BIT_FN5] || pin_in[PFS_PIN_P20];
    st_nxt.s1_sda = !c[PFS_PIN_P21][PFS_BIT_FN5] || pin_in[PFS_PIN_P21];
    st_nxt.s2_sda = !c[PFS_PIN_P15][PFS_BIT_FN6] || pin_in[PFS_PIN_P15];
    st_nxt.cc_in[0] = c[PFS_PIN_P16][PFS_BIT_FN4] && pin_in[PFS_PIN_P16];
    st_nxt.cc_in[1] = c[PFS_PIN_P17][PFS_BIT_FN4] && pin_in[PFS_PIN_P17];
    st_nxt.cc_in[2] = c[PFS_PIN_P20][PFS_BIT_FN4] && pin_in[PFS_PIN_P20];
    st_nxt.cc_in[3] = c[PFS_PIN_P21][PFS_BIT_FN4] && pin_in[PFS_PIN_P21];
    st_nxt.t1 = c[PFS_PIN_P16][PFS_BIT_FN6] && pin_in[PFS_PIN_P16];
    st_nxt.t0 = c[PFS_PIN_P17][PFS_BIT_FN6] && pin_in[PFS_PIN_P17];
    st_nxt.t2 = c[PFS_PIN_P24][PFS_BIT_FN4] && pin_in[PFS_PIN_P24];
    st_nxt.mosi = c[PFS_PIN_P20][PFS_BIT_FN3] && pin_in[PFS_PIN_P20];
    st_nxt.miso = c[PFS_PIN_P21][PFS_BIT_FN3] && pin_in[PFS_PIN_P21];
    st_nxt.sck = c[PFS_PIN_P22][PFS_BIT_FN3] && pin_in[PFS_PIN_P22];
    st_nxt.ssn = !c[PFS_PIN_P23][PFS_BIT_FN3] || pin_in[PFS_PIN_P23];
    st_nxt.pwm_emergency_stop = (c[PFS_PIN_P22][PFS_BIT_FN5] && pin_in[PFS_PIN_P22])
              || (c[PFS_PIN_P23][PFS_BIT_FN5] && pin_in[PFS_PIN_P23]);
    st_nxt.rxd = !c[PFS_PIN_P23][PFS_BIT_FN4] || pin_in[PFS_PIN_P23];
  end

  // ==================================================================
  // Registers
  // ==================================================================
  // Reset leaves every function off, pads undriven and idle lines high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.cfg <= {PFS_NPIN{PFS_CFG_RST}};
      st_r.pin_oe_n <= 8'hff;
      st_r.m_sda <= 1'b1;
      st_r.m_scl <= 1'b1;
      st_r.s1_sda <= 1'b1;
      st_r.s1_scl <= 1'b1;
      st_r.s2_sda <= 1'b1;
      st_r.ssn <= 1'b1;
      st_r.rxd <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops.
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign pin_out = st_r.pin_out;
  assign pin_oe_n = st_r.pin_oe_n;
  assign gpio_in = st_r.gpio_in;
  assign shared_pin_irq_group0 = st_r.irq0;
  assign shared_pin_irq_group1 = st_r.irq1;
  assign pad_analog_select = st_r.analog;
  assign i2c_master_sda_in = st_r.m_sda;
  assign i2c_master_scl_in = st_r.m_scl;
  assign i2c_slave1_sda_in = st_r.s1_sda;
  assign i2c_slave1_scl_in = st_r.s1_scl;
  assign i2c_slave2_sda_in = st_r.s2_sda;
  assign pwm_emergency_in = st_r.pwm_emergency_stop;
  assign capcomp_in = st_r.cc_in;
  assign timer0_count_in = st_r.t0;
  assign timer1_count_in = st_r.t1;
  assign timer2_input_in = st_r.t2;
  assign spi_mosi_in = st_r.mosi;
  assign spi_miso_in = st_r.miso;
  assign spi_sck_in = st_r.sck;
  assign spi_ssn_in = st_r.ssn;
  assign uart2_rxd_in = st_r.rxd;

  // ==================================================================
  // Assertions
  // ==================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Helper: decoded address and a write that lands in a register this cycle.
  logic [3:0] dec_a;
  logic wr_hit;
  assign dec_a = pfs_decode(paddr);
  assign wr_hit = psel && penable && pready && pwrite && dec_a[3] && pstrb[0];

  a_cfg_write_lands: assert property (wr_hit |=> st_r.cfg[$past(dec_a[2:0])]
    == $past(pwdata[7:0])) else $error("Register write did not land.");
  a_apb_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("Ready is not a single access cycle.");
  a_apb_unmapped: assert property (psel && !penable && !dec_a[3] |=> pslverr)
    else $error("Unmapped address gave no error.");
  a_gpio_in_path: assert property (st_r.cfg[3][0] && pin_in[3] |=> gpio_in[3])
    else $error("GPIO input path broken.");
  a_irq_group0: assert property (1'b1 |=> shared_pin_irq_group0
    == $past(|(pin_in & {st_r.cfg[7][1], st_r.cfg[6][1], st_r.cfg[5][1], st_r.cfg[4][1],
                         st_r.cfg[3][1], st_r.cfg[2][1], st_r.cfg[1][1], st_r.cfg[0][1]})))
    else $error("Group zero combine wrong.");
  a_irq_group1: assert property (st_r.cfg[5][2] && pin_in[5] |=> shared_pin_irq_group1)
    else $error("Group one missed a pin.");
  a_irq_both: assert property (st_r.cfg[2][2:1] == 2'b11 && pin_in[2]
    |=> shared_pin_irq_group0 && shared_pin_irq_group1)
    else $error("Pin failed to feed both groups.");
  a_analog_release: assert property (st_r.cfg[0][7] |=> pin_oe_n[0] && pad_analog_select[0])
    else $error("Analog pin still driven.");
  a_slave2_pull_low: assert property (st_r.cfg[0][7:6] == 2'b01 && !i2c_slave2_sda_out
    |=> !pin_oe_n[0] && !pin_out[0]) else $error("Open-drain pull missing.");
  a_master_scl_in: assert property (st_r.cfg[3][6] |=> i2c_master_scl_in == $past(pin_in[3]))
    else $error("Master clock input not routed.");
  a_pwm_priority: assert property (st_r.cfg[1][7:5] == 3'b001
    |=> !pin_oe_n[1] && pin_out[1] == $past(motor_pwm_b_pos_out))
    else $error("PWM output not selected.");
  a_timer_release: assert property (st_r.cfg[1][7:6] == 2'b01 |=> pin_oe_n[1])
    else $error("Timer input pin driven.");
  a_emg_input: assert property (st_r.cfg[5][5]
    |=> pwm_emergency_in == $past(pin_in[5] || (st_r.cfg[6][5] && pin_in[6])))
    else $error("Emergency input not routed.");
  a_timer2_route: assert property (st_r.cfg[7][4]
    |=> timer2_input_in == $past(pin_in[7]))
    else $error("Timer 2 input not routed.");
  a_pwm_c_drive: assert property (st_r.cfg[7][7:5] == 3'b001
    |=> !pin_oe_n[7] && pin_out[7] == $past(motor_pwm_c_pos_out))
    else $error("PWM channel C not driven.");
  a_capcomp_route: assert property (st_r.cfg[1][4]
    |=> capcomp_in[0] == $past(pin_in[1]))
    else $error("Capture input not routed.");
  a_uart_tx_drive: assert property (st_r.cfg[5][7:4] == 4'b0001
    |=> !pin_oe_n[5] && pin_out[5] == $past(uart2_txd_out))
    else $error("UART transmit not driven.");

  c_reg_write: cover property (wr_hit);
  c_irq_both: cover property (shared_pin_irq_group0 && shared_pin_irq_group1);
  c_unmapped: cover property (pslverr);
  c_spi_sck: cover property (st_r.cfg[5][3] && !pin_oe_n[5]);
  c_open_drain: cover property (st_r.cfg[0][6] && !pin_oe_n[0]);

endmodule : pfs_pin_select

// >>> test/pfs_tb.sv
`timescale 1ns/10ps
// ==================================================================
// Self-checking bench of the pin function selection block.
// ==================================================================
module tb;
  import pfs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [PFS_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr;
  logic [7:0] pin_in = 8'h00, gpio_out = 8'h00, gpio_oe = 8'h00;
  logic [7:0] pin_out, pin_oe_n, gpio_in, pad_analog_select;
  logic irq0, irq1, m_sda_o = 1'b1, m_scl_o = 1'b1, s1_sda_o = 1'b1, s1_scl_o = 1'b1;
  logic s2_sda_o = 1'b1, m_sda_i, m_scl_i, s1_sda_i, s1_scl_i, s2_sda_i;
  logic pwm_bn = 1'b0, pwm_bp = 1'b0, pwm_cp = 1'b0, emg_i, t0_i, t1_i, t2_i;
  logic [3:0] cc_out = 4'h0, cc_oe = 4'h0, cc_in;
  logic mosi_o = 1'b0, mosi_oe = 1'b0, miso_o = 1'b0, miso_oe = 1'b0, sck_o = 1'b0;
  logic sck_oe = 1'b0, mosi_i, miso_i, sck_i, ssn_i, txd_o = 1'b1, rxd_i;
  int errors = 0;
  int tests_run = 0;
  logic [15:0] ra [8] = '{PFS_IDX_P15, PFS_IDX_P16, PFS_IDX_P17, PFS_IDX_P20,
                          PFS_IDX_P21, PFS_IDX_P22, PFS_IDX_P23, PFS_IDX_P24};

  // Clock of 25 ns period.
  always #12.5 pclk = ~pclk;

  pfs_pin_select uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .shared_pin_irq_group0(irq0), .shared_pin_irq_group1(irq1),
    .pad_analog_select(pad_analog_select), .i2c_master_sda_out(m_sda_o),
    .i2c_master_scl_out(m_scl_o), .i2c_slave1_sda_out(s1_sda_o),
    .i2c_slave1_scl_out(s1_scl_o), .i2c_slave2_sda_out(s2_sda_o),
    .i2c_master_sda_in(m_sda_i), .i2c_master_scl_in(m_scl_i), .i2c_slave1_sda_in(s1_sda_i),
    .i2c_slave1_scl_in(s1_scl_i), .i2c_slave2_sda_in(s2_sda_i),
    .motor_pwm_b_neg_out(pwm_bn), .motor_pwm_b_pos_out(pwm_bp),
    .motor_pwm_c_pos_out(pwm_cp), .pwm_emergency_in(emg_i), .capcomp_out(cc_out),
    .capcomp_oe(cc_oe), .capcomp_in(cc_in), .timer0_count_in(t0_i),
    .timer1_count_in(t1_i), .timer2_input_in(t2_i), .spi_mosi_out(mosi_o),
    .spi_mosi_oe(mosi_oe), .spi_miso_out(miso_o), .spi_miso_oe(miso_oe),
    .spi_sck_out(sck_o), .spi_sck_oe(sck_oe), .spi_mosi_in(mosi_i), .spi_miso_in(miso_i),
    .spi_sck_in(sck_i), .spi_ssn_in(ssn_i), .uart2_txd_out(txd_o), .uart2_rxd_in(rxd_i));

  // ================================================================
  // Shared tasks.
  // ================================================================
  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask : chk

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Writes one configuration register by pin position.
  task automatic cfg(input int p, input logic [7:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, ra[p], v, d, e);
  endtask : cfg

  // Applies pad levels and lets the one-cycle latency pass.
  task automatic pads(input logic [7:0] v);
    @(posedge pclk);
    pin_in <= v;
    repeat (2) @(posedge pclk);
    #1;
  endtask : pads

  // ================================================================
  // Scenarios.
  // ================================================================
  // Reset values, write and read back, and an unmapped address.
  task automatic t_regs;
    logic [31:0] d;
    logic e;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ra[i], 8'h00, d, e);
      chk("reset value", 32'h0, d);
      cfg(i, 8'h5a ^ 8'(i));
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ra[i], 8'h00, d, e);
      chk("readback", {24'h0, 8'h5a ^ 8'(i)}, d);
      chk("slave error", 32'h0, {31'h0, e});
      cfg(i, 8'h00);
    end
    apb(1'b0, 16'ha060, 8'h00, d, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    $display("test regs done");
  endtask : t_regs

  // Interrupt groups and GPIO input over a walk of pad levels.
  task automatic t_irq;
    logic [7:0] pv [4] = '{8'h01, 8'h02, 8'h0c, 8'h00};
    cfg(0, 8'h02);
    cfg(1, 8'h04);
    cfg(2, 8'h06);
    cfg(3, 8'h01);
    for (int i = 0; i < 4; i++) begin
      pads(pv[i]);
      chk("group0", {31'h0, pv[i][0] | pv[i][2]}, {31'h0, irq0});
      chk("group1", {31'h0, pv[i][1] | pv[i][2]}, {31'h0, irq1});
      chk("gpio_in", {24'h0, pv[i] & 8'h08}, {24'h0, gpio_in});
    end
    for (int i = 0; i < 4; i++) cfg(i, 8'h00);
    $display("test irq done");
  endtask : t_irq

  // Output functions, priority, open-drain data and analog release.
  task automatic t_drive;
    cfg(0, 8'h20);
    cfg(1, 8'h20);
    cfg(7, 8'h20);
    cfg(3, 8'h08);
    @(posedge pclk);
    {pwm_bn, pwm_bp, pwm_cp, mosi_o, mosi_oe} <= 5'b10111;
    pads(8'h00);
    chk("pwm pins", 32'h89, {24'h0, pin_out & 8'h8b});
    chk("pwm enables", 32'h0, {24'h0, pin_oe_n & 8'h8b});
    cfg(0, 8'h30);
    m_sda_o <= 1'b0;
    pads(8'h00);
    chk("priority", 32'h1, {31'h0, pin_out[0]});
    cfg(0, 8'h10);
    pads(8'h00);
    chk("sda pulls low", 32'h0, {30'h0, pin_out[0], pin_oe_n[0]});
    chk("sda level", 32'h0, {31'h0, m_sda_i});
    @(posedge pclk);
    m_sda_o <= 1'b1;
    pads(8'h01);
    chk("sda release", 32'h1, {31'h0, pin_oe_n[0]});
    chk("sda high", 32'h1, {31'h0, m_sda_i});
    cfg(0, 8'h80);
    pads(8'h00);
    chk("analog", 32'h11, {27'h0, pin_oe_n[0], 3'h0, pad_analog_select[0]});
    for (int i = 0; i < 8; i++) cfg(i, 8'h00);
    $display("test drive done");
  endtask : t_drive

  // Input-only functions follow their pads at both levels.
  task automatic t_inputs;
    cfg(1, 8'h40);
    cfg(2, 8'h40);
    cfg(7, 8'h10);
    cfg(5, 8'h20);
    cfg(6, 8'h18);
    for (int v = 0; v < 2; v++) begin
      pads(v[0] ? 8'hff : 8'h00);
      chk("timer1", v, {31'h0, t1_i});
      chk("timer0", v, {31'h0, t0_i});
      chk("timer2", v, {31'h0, t2_i});
      chk("emergency", v, {31'h0, emg_i});
      chk("uart rx", v, {31'h0, rxd_i});
      chk("spi select", v, {31'h0, ssn_i});
    end
    $display("test inputs done");
  endtask : t_inputs

  // Open-drain pulls, SPI clock and capture lines in both directions; GPIO and UART outputs only.
  task automatic t_links;
    cfg(0, 8'h40);
    cfg(3, 8'h40);
    cfg(4, 8'h20);
    cfg(5, 8'h0c);
    {s2_sda_o, m_scl_o, s1_sda_o, sck_o, sck_oe} <= 5'b00011;
    pads(8'h30);
    chk("link enables", 32'h0, {24'h0, pin_oe_n & 8'h39});
    chk("link levels", 32'h20, {24'h0, pin_out & 8'h39});
    chk("link inputs", 32'h0f,
        {26'h0, s2_sda_i, m_scl_i, s1_sda_i, s1_scl_i, sck_i, irq1});
    cfg(0, 8'h01);
    cfg(1, 8'h10);
    cfg(4, 8'h08);
    cfg(5, 8'h10);
    cfg(3, 8'h08);
    {gpio_out[0], gpio_oe[0], cc_out[0], cc_oe[0], miso_o, miso_oe, txd_o} <= 7'b1111110;
    pads(8'h0a);
    chk("port enables", 32'h0, {24'h0, pin_oe_n & 8'h3b});
    chk("port levels", 32'h1b, {24'h0, pin_out & 8'h3b});
    chk("port inputs", 32'h05, {26'h0, cc_in, miso_i, mosi_i});
    $display("test links done");
  endtask : t_links

  // ================================================================
  // Verdict and sequence.
  // ================================================================
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Watchdog that cuts a hang short.
  initial begin
    #200000;
    errors++;
    test_done;
  end

  // Main sequence.
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("reset enables", 32'hff, {24'h0, pin_oe_n});
    chk("reset idle high", 32'h3, {30'h0, ssn_i, rxd_i});
    t_regs;
    t_irq;
    t_drive;
    t_inputs;
    t_links;
    test_done;
  end
endmodule : tb
